// file: logic/hpg_port_group.sv
// Handshake port group: one, two or four 8-bit ports joined into one handshaked parallel word
`timescale 1ns/1ps
`include "hpg_cfg.svh"

module hpg_port_group #(
  parameter int LINE_READ_LOW_IS_ONE = 0
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // Group configuration
  input  wire logic                 cfg_apply,
  input  wire hpg_pkg::hpg_width_t  port_group_width,
  input  wire hpg_pkg::hpg_port_t   cfg_first_port,
  input  wire logic                 cfg_dir,
  output logic                      cfg_error,
  // Handshake mode
  input  wire logic                 mode_apply,
  input  wire logic                 handshake_style_sel,
  input  wire logic                 edge_sel,
  input  wire logic                 req_line_invert,
  input  wire logic                 ack_line_invert,
  input  wire logic [2:0]           data_settle_delay,
  // Group word write
  input  wire logic                 wr_strobe,
  input  wire logic [31:0]          wr_data,
  output logic                      wr_error,
  // Group word read
  input  wire logic                 rd_strobe,
  output logic                      rd_valid,
  output logic                      rd_error,
  output logic [31:0]               rd_data,
  // Status query
  input  wire logic                 status_strobe,
  output logic                      status_valid,
  output logic                      status_error,
  output logic                      status_value,
  // Single line read
  input  wire logic                 line_strobe,
  input  wire hpg_pkg::hpg_port_t   line_port,
  input  wire logic [2:0]           line_index,
  output logic                      line_valid,
  output logic                      line_state,
  // Port pins
  input  wire logic [31:0]          port_in,
  output logic [31:0]               port_out,
  output logic [31:0]               port_oe,
  // Handshake pins
  output logic                      req_line,
  input  wire logic                 ack_line,
  output logic                      latched_data_flag
);
  import hpg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding functions

  // Ports owned for a width and first port; zero marks width zero or an illegal pairing
  function automatic logic [3:0] group_mask(input hpg_width_t w, input hpg_port_t p);
    logic [3:0] m;
    m = 4'h0;
    if (w == `HPG_WIDTH_ONE) begin
      m = 4'h1 << p;
    end else if (w == `HPG_WIDTH_TWO && !p[0]) begin
      m = p[1] ? 4'hC : 4'h3;
    end else if (w == `HPG_WIDTH_FOUR && p == 2'h0) begin
      m = 4'hF;
    end
    return m;
  endfunction

  // Packs port bytes into the group word, lowest port in the top byte
  function automatic logic [31:0] pack_word(input logic [31:0] pv, input hpg_width_t w, input hpg_port_t p);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (w == `HPG_WIDTH_FOUR) begin
      r = {pv[7:0], pv[15:8], pv[23:16], pv[31:24]};
    end else if (w == `HPG_WIDTH_TWO) begin
      r = p[1] ? {16'h0000, pv[23:16], pv[31:24]} : {16'h0000, pv[7:0], pv[15:8]};
    end else if (w == `HPG_WIDTH_ONE) begin
      r = {24'h00_0000, pv[8*p +: 8]};
    end
    return r;
  endfunction

  // Byte of the group word that lands on port k
  function automatic logic [7:0] port_byte(input logic [31:0] wd, input hpg_width_t w, input hpg_port_t k);
    logic [7:0] b;
    b = wd[7:0];
    if (w == `HPG_WIDTH_FOUR) begin
      b = wd[8*(3-k) +: 8];
    end else if (w == `HPG_WIDTH_TWO) begin
      b = k[0] ? wd[7:0] : wd[15:8];
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [31:0] pin_meta;
  logic [31:0] pin_sync;
  logic        ack_meta;
  logic        ack_sync;
  logic        ack_prev;

  // Two stages on every pin before any logic reads it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= 32'h0000_0000;
      pin_sync <= 32'h0000_0000;
      ack_meta <= 1'h0;
      ack_sync <= 1'h0;
      ack_prev <= 1'h0;
    end else begin
      pin_meta <= port_in;
      pin_sync <= pin_meta;
      ack_meta <= ack_line;
      ack_sync <= ack_meta;
      ack_prev <= ack_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and mode registers

  hpg_width_t width;
  hpg_port_t  first_port;
  logic       dir;
  logic       style;
  logic       edge_fall;
  logic       req_inv;
  logic       ack_inv;
  logic [2:0] settle;

  wire  [3:0] new_mask  = group_mask(port_group_width, cfg_first_port);
  wire        cfg_legal = (port_group_width == `HPG_WIDTH_NONE) || (new_mask != 4'h0);
  wire        cfg_take  = cfg_apply && cfg_legal;
  wire  [3:0] mask      = group_mask(width, first_port);
  wire        has_ports = (mask != 4'h0);

  // Group assignment; width zero releases every port
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      width      <= `HPG_WIDTH_NONE;
      first_port <= 2'h0;
      dir        <= `HPG_DIR_INPUT;
    end else if (cfg_take) begin
      width      <= port_group_width;
      first_port <= cfg_first_port;
      dir        <= cfg_dir;
    end
  end

  // Handshake mode, loaded as a set
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      style     <= `HPG_STYLE_LEVEL;
      edge_fall <= `HPG_EDGE_RISING;
      req_inv   <= `HPG_INVERT_OFF;
      ack_inv   <= `HPG_INVERT_OFF;
      settle    <= `HPG_SETTLE_RESET;
    end else if (mode_apply) begin
      style     <= handshake_style_sel;
      edge_fall <= edge_sel;
      req_inv   <= req_line_invert;
      ack_inv   <= ack_line_invert;
      settle    <= data_settle_delay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge detection

  wire ack_act      = ack_sync ^ ack_inv;
  wire ack_act_prev = ack_prev ^ ack_inv;
  wire ack_rise     = ack_act && !ack_act_prev;
  wire ack_fall     = !ack_act && ack_act_prev;
  wire ack_edge     = edge_fall ? ack_fall : ack_rise;
  wire ack_event    = style ? ack_edge : ack_act;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake sequencer

  hpg_state_t  state;
  hpg_state_t  next_state;
  logic [5:0]  settle_cnt;
  logic        flag;
  logic [31:0] in_latch;
  logic [31:0] drive;

  wire       is_out    = (dir == `HPG_DIR_OUTPUT);
  wire       wr_take   = wr_strobe && has_ports && is_out && flag && !cfg_take;
  wire       rd_take   = rd_strobe && has_ports;
  wire [5:0] settle_ld = 6'(settle * `HPG_SETTLE_STEP_CYC);
  wire       settle_ok = (settle_cnt == 6'h00);

  // Next state of the sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      HPG_OFF: begin
        next_state = HPG_OFF;
      end
      HPG_SETTLE: begin
        if (settle_ok) begin
          next_state = HPG_WAIT;
        end
      end
      HPG_WAIT: begin
        if (ack_event) begin
          next_state = HPG_HELD;
        end
      end
      HPG_HELD: begin
        if (!is_out && rd_take) begin
          next_state = HPG_WAIT;
        end else if (wr_take) begin
          next_state = (settle_ld == 6'h00) ? HPG_WAIT : HPG_SETTLE;
        end
      end
    endcase
    if (cfg_take) begin
      if (port_group_width == `HPG_WIDTH_NONE) begin
        next_state = HPG_OFF;
      end else begin
        next_state = (cfg_dir == `HPG_DIR_OUTPUT) ? HPG_HELD : HPG_WAIT;
      end
    end
  end

  // Request is held in level style, one cycle on entry in pulsed style
  wire enter_wait = (next_state == HPG_WAIT) && (state != HPG_WAIT || cfg_take);
  wire next_req   = style ? enter_wait : (next_state == HPG_WAIT);

  // Flag set by the far side latch or by an output group setting, cleared by host use or release
  wire next_flag = (next_state == HPG_HELD);

  // Sequencer, flag and request pin
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state             <= HPG_OFF;
      flag              <= 1'h0;
      latched_data_flag <= 1'h0;
      req_line          <= 1'h0;
    end else begin
      state             <= next_state;
      flag              <= next_flag;
      latched_data_flag <= next_flag;
      req_line          <= next_req ^ req_inv;
    end
  end

  // Settle counter loaded when new data starts to drive
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt <= 6'h00;
    end else if (wr_take) begin
      settle_cnt <= (settle_ld == 6'h00) ? 6'h00 : 6'(settle_ld - 6'h01);
    end else if (!settle_ok) begin
      settle_cnt <= 6'(settle_cnt - 6'h01);
    end
  end

  // Input latch takes all ports on the same edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      in_latch <= 32'h0000_0000;
    end else if (state == HPG_WAIT && !is_out && ack_event) begin
      in_latch <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drivers

  logic [31:0] next_drive;
  logic [31:0] next_oe;

  // Per port byte placement and enable
  generate
    for (genvar k = 0; k < `HPG_NUM_PORTS; k++) begin : g_port
      assign next_drive[8*k +: 8] = wr_take ? port_byte(wr_data, width, hpg_port_t'(k)) : drive[8*k +: 8];
      assign next_oe[8*k +: 8]    = cfg_take ? {8{new_mask[k] && (cfg_dir == `HPG_DIR_OUTPUT)}}
                                             : {8{mask[k] && is_out}};
    end
  endgenerate

  // All owned ports update on the same edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drive    <= 32'h0000_0000;
      port_out <= 32'h0000_0000;
      port_oe  <= 32'h0000_0000;
    end else begin
      drive    <= next_drive;
      port_out <= next_drive;
      port_oe  <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host answers

  wire [31:0] rd_src      = is_out ? drive : in_latch;
  wire [31:0] next_rd     = pack_word(rd_src, width, first_port);
  wire [31:0] line_src    = (mask[line_port] && is_out) ? drive : pin_sync;
  wire        line_bit    = line_src[{line_port, line_index}];
  wire        next_line   = (LINE_READ_LOW_IS_ONE != 0) ? !line_bit : line_bit;

  // One-cycle answers to each strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid     <= 1'h0;
      rd_error     <= 1'h0;
      rd_data      <= 32'h0000_0000;
      status_valid <= 1'h0;
      status_error <= 1'h0;
      status_value <= 1'h0;
      wr_error     <= 1'h0;
      cfg_error    <= 1'h0;
      line_valid   <= 1'h0;
      line_state   <= 1'h0;
    end else begin
      rd_valid     <= rd_take;
      rd_error     <= rd_strobe && !has_ports;
      rd_data      <= rd_take ? next_rd : 32'h0000_0000;
      status_valid <= status_strobe;
      status_error <= status_strobe && !has_ports;
      status_value <= status_strobe && has_ports && flag;
      wr_error     <= wr_strobe && !wr_take;
      cfg_error    <= cfg_apply && !cfg_legal;
      line_valid   <= line_strobe;
      line_state   <= line_strobe ? next_line : 1'h0;
    end
  end

endmodule

// file: include/hpg_cfg.svh
// Constants for the handshake port group: widths, codes, reset values and timing
`ifndef HPG_CFG_SVH
`define HPG_CFG_SVH

// Port and word geometry
`define HPG_NUM_PORTS        4
`define HPG_PORT_BITS        8
`define HPG_WORD_BITS        32

// Group width codes, in ports
`define HPG_WIDTH_NONE       3'h0
`define HPG_WIDTH_ONE        3'h1
`define HPG_WIDTH_TWO        3'h2
`define HPG_WIDTH_FOUR       3'h4

// Direction codes
`define HPG_DIR_INPUT        1'h0
`define HPG_DIR_OUTPUT       1'h1

// Mode codes and reset values
`define HPG_STYLE_LEVEL      1'h0
`define HPG_STYLE_PULSED     1'h1
`define HPG_EDGE_RISING      1'h0
`define HPG_EDGE_FALLING     1'h1
`define HPG_INVERT_OFF       1'h0
`define HPG_SETTLE_RESET     3'h0

// Timing: settle step of 100 ns on a 100 ns clock, least time rounds up
`define HPG_SETTLE_STEP_NS   100
`define HPG_CLK_PERIOD_NS    100
`define HPG_SETTLE_STEP_CYC  ((`HPG_SETTLE_STEP_NS + `HPG_CLK_PERIOD_NS - 1) / `HPG_CLK_PERIOD_NS)

`endif

// file: include/hpg_pkg.sv
// Types shared by the handshake port group
package hpg_pkg;

  // Handshake sequencer states
  typedef enum logic [1:0] {
    HPG_OFF,
    HPG_SETTLE,
    HPG_WAIT,
    HPG_HELD
  } hpg_state_t;

  // Group width code, in ports
  typedef logic [2:0] hpg_width_t;

  // Port index
  typedef logic [1:0] hpg_port_t;

endpackage

// file: bench/hpg_port_group_chk.sv
// Checker of the handshake port group port behaviour
`timescale 1ns/1ps
module hpg_port_group_chk (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               nrst,
  // Configuration and mode
  input wire logic               cfg_apply,
  input wire hpg_pkg::hpg_width_t port_group_width,
  input wire hpg_pkg::hpg_port_t cfg_first_port,
  input wire logic               cfg_dir,
  input wire logic               cfg_error,
  input wire logic               mode_apply,
  input wire logic               handshake_style_sel,
  input wire logic               req_line_invert,
  input wire logic [2:0]         data_settle_delay,
  // Host accesses
  input wire logic               wr_strobe,
  input wire logic               wr_error,
  input wire logic               rd_strobe,
  input wire logic               rd_error,
  input wire logic               status_strobe,
  input wire logic               status_valid,
  input wire logic               status_error,
  input wire logic               status_value,
  // Pins
  input wire logic [31:0]        port_oe,
  input wire logic               req_line,
  input wire logic               latched_data_flag
);
  import hpg_pkg::*;
  logic       own;
  logic       dir_o;
  logic       ri;
  logic       pls;
  logic [2:0] n;
  logic [3:0] cnt;
  wire w2 = port_group_width == 3'h2 && !cfg_first_port[0];
  wire w4 = port_group_width == 3'h4 && cfg_first_port == 2'h0;
  wire legal = port_group_width < 3'h2 || w2 || w4;
  wire req_act = req_line ^ ri;
  wire take = wr_strobe && own && dir_o && latched_data_flag && !cfg_apply;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // Group, mode and settle count as the host set them
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      own   <= 1'h0;
      dir_o <= 1'h0;
    end else if (cfg_apply && legal) begin
      own   <= port_group_width != 3'h0;
      dir_o <= cfg_dir;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ri  <= 1'h0;
      pls <= 1'h0;
      n   <= 3'h0;
    end else if (mode_apply) begin
      ri  <= req_line_invert;
      pls <= handshake_style_sel;
      n   <= data_settle_delay;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'hF;
    end else if (take) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    take;
  endsequence
  sequence s_settling;
    own && dir_o && !latched_data_flag;
  endsequence
  property p_rd_none;
    rd_strobe && !own |=> rd_error;
  endproperty
  a_rd_none: assert property (p_rd_none) else $error("read without ports not refused");
  property p_st_none;
    status_strobe && !own |=> status_valid && status_error && !status_value;
  endproperty
  a_st_none: assert property (p_st_none) else $error("status without ports wrong");
  property p_cfg_err;
    cfg_apply && !legal |=> cfg_error;
  endproperty
  a_cfg_err: assert property (p_cfg_err) else $error("illegal port set accepted");
  property p_off;
    !own && !$past(mode_apply) |-> !latched_data_flag && port_oe == 32'h0 && !req_act;
  endproperty
  a_off: assert property (p_off) else $error("group without ports not idle");
  property p_wr_refuse;
    wr_strobe && !(own && dir_o && latched_data_flag) |=> wr_error;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("early write not refused");
  property p_wr_take;
    s_take |=> !latched_data_flag && !wr_error;
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write did not clear flag");
  property p_settle;
    s_settling ##0 cnt < {1'h0, n} |-> !req_act;
  endproperty
  a_settle: assert property (p_settle) else $error("request before settle time");
  property p_req_on;
    s_settling ##0 cnt == {1'h0, n} |-> req_act;
  endproperty
  a_req_on: assert property (p_req_on) else $error("request late after settle");
  property p_pulse;
    own && pls && $rose(req_act) |=> !req_act;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulsed request not one cycle");
endmodule

bind hpg_port_group hpg_port_group_chk u_hpg_port_group_chk (.sys_clk, .nrst, .cfg_apply,
  .port_group_width, .cfg_first_port, .cfg_dir, .cfg_error, .mode_apply, .handshake_style_sel,
  .req_line_invert, .data_settle_delay, .wr_strobe, .wr_error, .rd_strobe, .rd_error,
  .status_strobe, .status_valid, .status_error, .status_value, .port_oe, .req_line,
  .latched_data_flag);

// file: bench/hpg_far_sys.sv
// Far-side system: acknowledges requests, latches output words, drives input pins
`timescale 1ns/1ps
module hpg_far_sys #(
  parameter int DLY = 1
) (
  // Clock
  input  wire logic        sys_clk,
  // Handshake
  input  wire logic        req_line,
  input  wire logic        req_inv,
  input  wire logic        ack_inv,
  output logic             ack_line,
  // Pins
  input  wire logic [31:0] drive_word,
  input  wire logic [31:0] port_out,
  input  wire logic [31:0] port_oe,
  output logic [31:0]      port_in,
  output logic [31:0]      got_word
);
  int   cnt = 0;
  logic ack_act = 1'h0;
  // Pin levels resolved from both drivers
  assign ack_line = ack_act ^ ack_inv;
  assign port_in = (port_oe & port_out) | (~port_oe & drive_word);
  // Two-cycle acknowledge some cycles after each request
  always @(posedge sys_clk) begin
    if (cnt == 0 && (req_line ^ req_inv)) begin
      cnt <= 1;
    end else if (cnt > 0 && cnt < DLY + 4) begin
      cnt <= cnt + 1;
    end else if (cnt != 0 && !(req_line ^ req_inv)) begin
      cnt <= 0;
    end
    ack_act <= cnt == DLY || cnt == DLY + 1;
    if (cnt == DLY) begin
      got_word <= port_out;
    end
  end
endmodule

// file: bench/hpg_port_group_tb_top.sv
// Testbench of the handshake port group against the far-side model
`timescale 1ns/1ps
module hpg_port_group_tb_top;
  import hpg_pkg::*;
  logic        sys_clk, nrst, cfg_apply, cfg_dir, mode_apply, handshake_style_sel, edge_sel;
  logic        req_line_invert, ack_line_invert, wr_strobe, rd_strobe, status_strobe, line_strobe;
  logic        cfg_error, wr_error, rd_valid, rd_error, status_valid, status_error, status_value;
  logic        line_valid, line_state, req_line, ack_line, latched_data_flag;
  hpg_width_t  port_group_width;
  hpg_port_t   cfg_first_port, line_port;
  logic [2:0]  data_settle_delay, line_index;
  logic [31:0] wr_data, rd_data, port_in, port_out, port_oe, drive_word, got_word;
  int          err_total = 0;
  int          check_count = 0;
  hpg_port_group u_hpg_port_group (.sys_clk, .nrst, .cfg_apply, .port_group_width, .cfg_first_port,
    .cfg_dir, .cfg_error, .mode_apply, .handshake_style_sel, .edge_sel, .req_line_invert,
    .ack_line_invert, .data_settle_delay, .wr_strobe, .wr_data, .wr_error, .rd_strobe, .rd_valid,
    .rd_error, .rd_data, .status_strobe, .status_valid, .status_error, .status_value, .line_strobe,
    .line_port, .line_index, .line_valid, .line_state, .port_in, .port_out, .port_oe, .req_line,
    .ack_line, .latched_data_flag);
  hpg_far_sys #(.DLY(1)) u_hpg_far_sys (.sys_clk, .req_line, .req_inv(req_line_invert),
    .ack_inv(ack_line_invert), .ack_line, .drive_word, .port_out, .port_oe, .port_in, .got_word);
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    err_total++;
    tally_and_finish;
  end
  // Shared helpers
  task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hit(ref logic s);
    s = 1'h1;
    @(negedge sys_clk);
    s = 1'h0;
  endtask
  task automatic do_cfg(hpg_width_t w, hpg_port_t p, logic d);
    port_group_width = w;
    cfg_first_port = p;
    cfg_dir = d;
    hit(cfg_apply);
  endtask
  task automatic wait_flag;
    for (int i = 0; i < 60 && latched_data_flag !== 1'h1; i++) begin
      @(negedge sys_clk);
    end
    cmp("flag", 32'h1, latched_data_flag);
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Startup state and refusals with no ports
  task automatic t_reset;
    cmp("req", 32'h0, req_line);
    cmp("oe", 32'h0, port_oe);
    hit(status_strobe);
    cmp("st_err", 32'h1, status_error);
    cmp("st_val", 32'h0, status_value);
    hit(rd_strobe);
    cmp("rd_err", 32'h1, rd_error);
  endtask
  // Input group latches the pins and packs them into the word
  task automatic t_in(hpg_width_t w, hpg_port_t p, logic [31:0] exp);
    do_cfg(w, p, 1'h0);
    wait_flag;
    hit(status_strobe);
    cmp("st_val", 32'h1, status_value);
    hit(rd_strobe);
    cmp("rd_data", exp, rd_data);
    cmp("flag_clr", 32'h0, latched_data_flag);
    line_port = p;
    line_index = 3'h4;
    hit(line_strobe);
    cmp("line", drive_word[{p, 3'h4}], line_state);
  endtask
  // Output group under one handshake mode
  task automatic t_out(logic [4:0] md, logic [2:0] n, hpg_width_t w, hpg_port_t p,
                       logic [31:0] word, logic [31:0] pins, logic [31:0] m);
    do_cfg(3'h0, 2'h0, 1'h0);
    {handshake_style_sel, edge_sel, req_line_invert, ack_line_invert} = md[3:0];
    data_settle_delay = n;
    hit(mode_apply);
    // A polarity change looks like a request to the far side; let that exchange die out
    repeat (8) @(negedge sys_clk);
    do_cfg(w, p, 1'h1);
    cmp("flag_out", 32'h1, latched_data_flag);
    wr_data = word;
    hit(wr_strobe);
    cmp("wr_err", 32'h0, wr_error);
    cmp("oe", m, port_oe);
    cmp("pins", pins, port_out & m);
    hit(wr_strobe);
    cmp("wr_ref", 32'h1, wr_error);
    wait_flag;
    cmp("far", pins, got_word & m);
    hit(rd_strobe);
    cmp("rdback", word, rd_data);
    line_port = p;
    line_index = 3'h4;
    hit(line_strobe);
    cmp("line", pins[{p, 3'h4}], line_state);
  endtask
  // Illegal settings, write to input group, release of ports
  task automatic t_bad;
    do_cfg(3'h2, 2'h1, 1'h0);
    cmp("cfg_err", 32'h1, cfg_error);
    do_cfg(3'h3, 2'h0, 1'h0);
    cmp("cfg_err", 32'h1, cfg_error);
    do_cfg(3'h1, 2'h0, 1'h0);
    hit(wr_strobe);
    cmp("wr_in", 32'h1, wr_error);
    do_cfg(3'h0, 2'h0, 1'h0);
    cmp("off_flag", 32'h0, latched_data_flag);
    cmp("off_oe", 32'h0, port_oe);
  endtask
  // Main sequence
  initial begin
    {cfg_apply, cfg_dir, mode_apply, handshake_style_sel, edge_sel, req_line_invert} = '0;
    {ack_line_invert, wr_strobe, rd_strobe, status_strobe, line_strobe} = '0;
    {port_group_width, cfg_first_port, line_port, data_settle_delay, line_index, wr_data} = '0;
    drive_word = 32'h11223344;
    nrst = 1'h0;
    repeat (8) @(negedge sys_clk);
    nrst = 1'h1;
    @(negedge sys_clk);
    t_reset;
    t_in(3'h4, 2'h0, 32'h44332211);
    t_in(3'h2, 2'h0, 32'h00004433);
    t_in(3'h2, 2'h2, 32'h00002211);
    t_in(3'h1, 2'h1, 32'h00000033);
    t_out(5'h00, 3'h0, 3'h4, 2'h0, 32'hA1B2C3D4, 32'hD4C3B2A1, 32'hFFFFFFFF);
    t_out(5'h0B, 3'h3, 3'h2, 2'h2, 32'h0000A1B2, 32'hB2A10000, 32'hFFFF0000);
    t_out(5'h0D, 3'h7, 3'h1, 2'h1, 32'h000000C5, 32'h0000C500, 32'h0000FF00);
    t_out(5'h02, 3'h1, 3'h2, 2'h0, 32'h0000A1B2, 32'h0000B2A1, 32'h0000FFFF);
    t_bad;
    tally_and_finish;
  end
endmodule
